// [verilog/stiu_defs.vh]
// Purpose: constants for the signed table interpolate unit
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: definitions only
`ifndef STIU_DEFS_VH
`define STIU_DEFS_VH
// ==========================================================
// opcode and extension word fields
`define STIU_OP_PREFIX 10'h3e0
`define STIU_EXT_SIGNED 11
`define STIU_EXT_ROUND 10
`define STIU_EXT_TABLE 8
// ==========================================================
// sizes and effective address modes
`define STIU_SZ_BYTE 2'h0
`define STIU_SZ_WORD 2'h1
`define STIU_SZ_LONG 2'h2
`define STIU_EA_DREG 3'h0
`define STIU_EA_IND 3'h2
`define STIU_EA_DISP 3'h5
`define STIU_EA_IDX 3'h6
`define STIU_EA_EXT 3'h7
`define STIU_EA_ABSW 3'h0
`define STIU_EA_ABSL 3'h1
`define STIU_EA_PCD 3'h2
`define STIU_EA_PCX 3'h3
`endif

// [verilog/stiu_decode.v]
// Purpose: decode the interpolate opcode and extension words
// Assumes: words are stable while valid
// Notes: purely combinational
`timescale 1ns/1ps
`include "stiu_defs.vh"
module stiu_decode (
   // instruction words
   input wire [15:0] op_word_i,
   input wire [15:0] ext_word_i,
   // decoded fields
   output wire legal_o,
   output wire table_mode_o,
   output wire no_round_option_o,
   output wire is_signed_o,
   output wire [1:0] size_o,
   output wire [2:0] dest_sel_o,
   output wire [2:0] src_a_sel_o,
   output wire [2:0] src_b_sel_o
);
   // ==========================================================
   // field extraction
   wire [2:0] ea_mode = op_word_i[5:3];
   wire [2:0] ea_reg = op_word_i[2:0];
   wire prefix_ok = (op_word_i[15:6] == `STIU_OP_PREFIX);
   wire size_ok = (ext_word_i[7:6] != 2'h3);
   // control modes only; postincrement, predecrement, direct, immediate refused
   wire ea_ok = (ea_mode == `STIU_EA_IND) || (ea_mode == `STIU_EA_DISP) ||
      (ea_mode == `STIU_EA_IDX) ||
      ((ea_mode == `STIU_EA_EXT) && ((ea_reg == `STIU_EA_ABSW) || (ea_reg == `STIU_EA_ABSL) ||
      (ea_reg == `STIU_EA_PCD) || (ea_reg == `STIU_EA_PCX)));
   // register mode: ea mode zero and table bit clear
   wire reg_ok = (ea_mode == `STIU_EA_DREG) && !ext_word_i[`STIU_EXT_TABLE];
   wire tab_ok = ext_word_i[`STIU_EXT_TABLE] && ea_ok;
   assign legal_o = prefix_ok && size_ok && (tab_ok || reg_ok);
   assign table_mode_o = ext_word_i[`STIU_EXT_TABLE];
   assign no_round_option_o = ext_word_i[`STIU_EXT_ROUND];
   assign is_signed_o = ext_word_i[`STIU_EXT_SIGNED];
   assign size_o = ext_word_i[7:6];
   assign dest_sel_o = ext_word_i[14:12];
   assign src_a_sel_o = ea_reg;
   assign src_b_sel_o = ext_word_i[2:0];
endmodule // stiu_decode

// [verilog/stiu_sizeext.v]
// Purpose: extend an entry of the chosen size to 33 bits
// Assumes: size is byte, word or long
// Notes: used once per table entry
`timescale 1ns/1ps
`include "stiu_defs.vh"
module stiu_sizeext (
   // operand
   input wire [31:0] val_i,
   input wire [1:0] size_i,
   input wire is_signed_i,
   // extended value
   output reg [32:0] ext_o
);
   // ==========================================================
   // two's-complement or zero extension by size
   always @* begin
      case (size_i)
         `STIU_SZ_BYTE: ext_o = {{25{is_signed_i & val_i[7]}}, val_i[7:0]};
         `STIU_SZ_WORD: ext_o = {{17{is_signed_i & val_i[15]}}, val_i[15:0]};
         default: ext_o = {is_signed_i & val_i[31], val_i};
      endcase
   end
endmodule // stiu_sizeext

// [verilog/stiu_unit.v]
// Purpose: table lookup and linear interpolate datapath
// Assumes: sequencer holds words and register values while busy
// Notes: Operation
// Operation
// - table index from dest high byte
// - address is base plus index times size
// - difference next minus first, times fraction
// - register mode uses two sources, fraction only
// - entries are n-bit two's complement
// - rounded and unrounded result formulas
// - round bit zero rounds, one does not
// - round adjustment by half thresholds
// - rounded result writes only sized bits
// - unrounded integer placed above fraction byte
// - unrounded byte/word sign extended
// - fraction byte in bits seven to zero
// - flags N Z, X kept, C cleared
// - V on long integer outside 24 bits
// - size 00 byte, 01 word, 10 long
// - table mode accepts control modes only
// - zero mode field selects register mode
// - opcode prefix and extension layout
// - dest register gives input, takes result
// - unsigned variant zero-extends unrounded results
`timescale 1ns/1ps
`include "stiu_defs.vh"
module stiu_unit (
   // clock and reset
   input wire clk_i,
   input wire reset_i,
   // instruction from the sequencer
   input wire start_i,
   input wire [15:0] op_word_i,
   input wire [15:0] ext_word_i,
   input wire [31:0] table_base_operand_i,
   // register file read ports
   output wire [2:0] rd_a_sel_o,
   output wire [2:0] rd_b_sel_o,
   output wire [2:0] rd_d_sel_o,
   input wire [31:0] rd_a_data_i,
   input wire [31:0] rd_b_data_i,
   input wire [31:0] dest_data_reg_i,
   // operand memory read
   output reg mem_req_o,
   output reg [31:0] mem_addr_ff_o,
   output reg [1:0] mem_size_ff_o,
   input wire mem_ack_i,
   input wire [31:0] mem_rdata_i,
   // result write back
   output reg wr_en_o,
   output reg [2:0] wr_sel_ff_o,
   output reg [31:0] wr_data_ff_o,
   output reg [4:0] ccr_ff_o,
   input wire [4:0] ccr_i,
   // status
   output wire busy_o,
   output reg illegal_o
);
   // ==========================================================
   // state machine, one-hot
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_FETCH0 = 6'h02;
   localparam [5:0] S_FETCH1 = 6'h04;
   localparam [5:0] S_CALC = 6'h08;
   localparam [5:0] S_DONE = 6'h10;
   localparam [5:0] S_ILL = 6'h20;
   reg [5:0] state_ff;
   reg [5:0] nxt_state;
   reg [31:0] ent0_ff;
   reg [31:0] ent1_ff;
   reg [15:0] dvar_ff;
   reg [31:0] dold_ff;
   reg [31:0] nxt_wdata;
   reg [4:0] nxt_ccr;
   // ==========================================================
   // decode
   wire legal;
   wire table_mode;
   wire no_round_option;
   wire is_signed;
   wire [1:0] size;
   wire [2:0] dest_sel;
   stiu_decode u_dec (
      .op_word_i(op_word_i),
      .ext_word_i(ext_word_i),
      .legal_o(legal),
      .table_mode_o(table_mode),
      .no_round_option_o(no_round_option),
      .is_signed_o(is_signed),
      .size_o(size),
      .dest_sel_o(dest_sel),
      .src_a_sel_o(rd_a_sel_o),
      .src_b_sel_o(rd_b_sel_o)
   );
   assign rd_d_sel_o = dest_sel;
   assign busy_o = !state_ff[0];
   // ==========================================================
   // table address: index scaled by operand size
   wire [31:0] idx = {24'h000000, dest_data_reg_i[15:8]};
   reg [31:0] scaled_idx;
   always @* begin
      case (size)
         `STIU_SZ_BYTE: scaled_idx = idx;
         `STIU_SZ_WORD: scaled_idx = {idx[30:0], 1'b0};
         default: scaled_idx = {idx[29:0], 2'b00};
      endcase
   end
   wire [31:0] addr0 = table_base_operand_i + scaled_idx;
   reg [31:0] step;
   always @* begin
      case (mem_size_ff_o)
         `STIU_SZ_BYTE: step = 32'h00000001;
         `STIU_SZ_WORD: step = 32'h00000002;
         default: step = 32'h00000004;
      endcase
   end
   // ==========================================================
   // arithmetic on the captured entries
   wire [32:0] e0x;
   wire [32:0] e1x;
   stiu_sizeext u_ext0 (
      .val_i(ent0_ff),
      .size_i(mem_size_ff_o),
      .is_signed_i(is_signed),
      .ext_o(e0x)
   );
   stiu_sizeext u_ext1 (
      .val_i(ent1_ff),
      .size_i(mem_size_ff_o),
      .is_signed_i(is_signed),
      .ext_o(e1x)
   );
   // 34-bit difference and 43-bit product: no overflow for long entries
   wire signed [33:0] diff = $signed({e1x[32], e1x}) - $signed({e0x[32], e0x});
   wire signed [42:0] prod = diff * $signed({1'b0, dvar_ff[7:0]});
   wire signed [42:0] base256 = $signed({{2{e0x[32]}}, e0x, 8'h00});
   wire signed [42:0] unr = base256 + prod;
   // round to nearest, symmetric about zero
   wire [7:0] pfrac = prod[7:0];
   wire signed [34:0] ptrunc = prod[42:8]; // floor of prod/256
   reg signed [34:0] adj;
   always @* begin
      if (!prod[42]) begin
         adj = ptrunc + (pfrac[7] ? 35'sd1 : 35'sd0);
      end else if (pfrac == 8'h00) begin
         adj = ptrunc;
      end else begin
         // negative: truncate toward zero, then -1 when fraction at most -1/2
         adj = ptrunc + 35'sd1 - ((pfrac <= 8'h80) ? 35'sd1 : 35'sd0);
      end
   end
   wire signed [34:0] rnd = $signed({{2{e0x[32]}}, e0x}) + adj;
   wire [34:0] uint = unr[42:8];
   // ==========================================================
   // result merge and condition codes
   always @* begin
      nxt_wdata = dold_ff;
      nxt_ccr = ccr_i;
      nxt_ccr[0] = 1'b0;
      nxt_ccr[1] = 1'b0;
      if (!no_round_option) begin
         case (mem_size_ff_o)
            `STIU_SZ_BYTE: begin
               nxt_wdata[7:0] = rnd[7:0];
               nxt_ccr[3] = rnd[7];
               nxt_ccr[2] = (rnd[7:0] == 8'h00);
            end
            `STIU_SZ_WORD: begin
               nxt_wdata[15:0] = rnd[15:0];
               nxt_ccr[3] = rnd[15];
               nxt_ccr[2] = (rnd[15:0] == 16'h0000);
            end
            default: begin
               nxt_wdata = rnd[31:0];
               nxt_ccr[3] = rnd[31];
               nxt_ccr[2] = (rnd[31:0] == 32'h00000000);
            end
         endcase
      end else begin
         case (mem_size_ff_o)
            `STIU_SZ_BYTE: nxt_wdata = {{16{is_signed & uint[7]}}, uint[7:0], unr[7:0]};
            `STIU_SZ_WORD: nxt_wdata = {{8{is_signed & uint[15]}}, uint[15:0], unr[7:0]};
            default: begin
               nxt_wdata = {uint[23:0], unr[7:0]};
               // integer part outside 24-bit range, signed or unsigned per is_signed
               nxt_ccr[1] = is_signed ? (uint[34:23] != {12{uint[23]}}) : (uint[34:24] != 11'h000);
            end
         endcase
         nxt_ccr[3] = nxt_wdata[31];
         nxt_ccr[2] = (nxt_wdata == 32'h00000000);
      end
   end
   // ==========================================================
   // next state
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (start_i) begin
               if (!legal) nxt_state = S_ILL;
               else if (table_mode) nxt_state = S_FETCH0;
               else nxt_state = S_CALC;
            end
         end
         S_FETCH0: if (mem_ack_i) nxt_state = S_FETCH1;
         S_FETCH1: if (mem_ack_i) nxt_state = S_CALC;
         S_CALC: nxt_state = S_DONE;
         S_DONE: nxt_state = S_IDLE;
         S_ILL: nxt_state = S_IDLE;
         default: nxt_state = S_IDLE;
      endcase
   end
   // ==========================================================
   // registers
   always @(posedge clk_i) begin
      if (reset_i) begin
         state_ff <= S_IDLE;
         ent0_ff <= 32'h00000000;
         ent1_ff <= 32'h00000000;
         dvar_ff <= 16'h0000;
         dold_ff <= 32'h00000000;
         mem_addr_ff_o <= 32'h00000000;
         mem_size_ff_o <= `STIU_SZ_BYTE;
         wr_sel_ff_o <= 3'h0;
         wr_data_ff_o <= 32'h00000000;
         ccr_ff_o <= 5'h00;
      end else begin
         state_ff <= nxt_state;
         if (state_ff[0] && start_i) begin
            dvar_ff <= dest_data_reg_i[15:0];
            dold_ff <= dest_data_reg_i;
            mem_addr_ff_o <= addr0;
            mem_size_ff_o <= size;
            wr_sel_ff_o <= dest_sel;
            ent0_ff <= rd_a_data_i;
            ent1_ff <= rd_b_data_i;
         end
         if (state_ff[1] && mem_ack_i) begin
            ent0_ff <= mem_rdata_i;
            mem_addr_ff_o <= mem_addr_ff_o + step;
         end
         if (state_ff[2] && mem_ack_i) ent1_ff <= mem_rdata_i;
         if (state_ff[3]) begin
            wr_data_ff_o <= nxt_wdata;
            ccr_ff_o <= nxt_ccr;
         end
      end
   end
   // ==========================================================
   // handshake outputs decoded from state
   always @* begin
      mem_req_o = state_ff[1] | state_ff[2];
      wr_en_o = state_ff[4];
      illegal_o = state_ff[5];
   end
endmodule // stiu_unit

// [verification/stiu_mem_model.sv]
// Purpose: operand memory answering the unit's entry fetches
// Assumes: one request at a time, address held until ack
// Notes: data is a hash of the address; lines toggle when not acked
`timescale 1ns/1ps
// =====================================================
// memory model
module stiu_mem_model (
   // clock and reset
   input wire clk_i,
   input wire reset_i,
   // fetch port
   input wire req_i,
   input wire [31:0] addr_i,
   input wire [1:0] lat_i,
   output reg ack_o,
   output reg [31:0] rdata_o
);
   reg [1:0] cnt_ff = 2'h0;
   // ack after lat_i wait cycles; stale data is never shown
   always @(posedge clk_i) begin
      if (reset_i || !req_i || ack_o || cnt_ff != lat_i) begin
         ack_o <= 1'b0;
         rdata_o <= reset_i ? 32'h5a5a5a5a : ~rdata_o;
         cnt_ff <= (reset_i || !req_i || ack_o) ? 2'h0 : cnt_ff + 2'h1;
      end else begin
         ack_o <= 1'b1;
         rdata_o <= addr_i * 32'h9e3779b1;
      end
   end
endmodule // stiu_mem_model

// [verification/stiu_unit_sva.sv]
// Purpose: port checker for stiu_unit
// Assumes: sequencer holds words and registers while busy
// Notes: bound into every stiu_unit
`timescale 1ns/1ps
// =====================================================
// checker
module stiu_unit_chk (
   // clock and reset
   input wire clk_i,
   input wire reset_i,
   // instruction side
   input wire start_i,
   input wire busy_o,
   input wire [15:0] op_word_i,
   input wire [15:0] ext_word_i,
   input wire [31:0] dest_data_reg_i,
   input wire [4:0] ccr_i,
   // results
   input wire mem_req_o,
   input wire wr_en_o,
   input wire illegal_o,
   input wire [2:0] wr_sel_ff_o,
   input wire [31:0] wr_data_ff_o,
   input wire [4:0] ccr_ff_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // decoded helpers
   wire nr = ext_word_i[10];
   wire [1:0] sz = ext_word_i[7:6];
   wire [2:0] md = op_word_i[5:3];
   sequence take_s;
      start_i && !busy_o && op_word_i[15:6] == 10'h3e0 && sz != 2'h3;
   endsequence
   sequence reg_go_s;
      take_s ##0 (md == 3'h0 && !ext_word_i[8]);
   endsequence
   sequence tbl_go_s;
      take_s ##0 (md == 3'h2 && ext_word_i[8]);
   endsequence
   reg_lat_a: assert property (reg_go_s |-> ##[2:3] wr_en_o) else $error("register mode result late");
   tbl_req_a: assert property (tbl_go_s |-> ##[1:2] mem_req_o) else $error("no table fetch");
   bad_op_a: assert property (start_i && !busy_o && op_word_i[15:6] != 10'h3e0 |=> illegal_o && !wr_en_o)
      else $error("bad prefix accepted");
   tbl_rej_a: assert property (start_i && !busy_o && ext_word_i[8] && (md == 3'h3 || md == 3'h4) |=> illegal_o)
      else $error("table mode took an alterable mode");
   c_clear_a: assert property (wr_en_o |-> !ccr_ff_o[0] && ccr_ff_o[4] == ccr_i[4]) else $error("carry or extend wrong");
   nz_flag_a: assert property (wr_en_o && nr |-> ccr_ff_o[3] == wr_data_ff_o[31] &&
      ccr_ff_o[2] == (wr_data_ff_o == 32'h0)) else $error("n or z flag wrong");
   keep_up_a: assert property (wr_en_o && !nr && sz != 2'h2 |-> wr_data_ff_o[31:16] == dest_data_reg_i[31:16] &&
      (sz != 2'h0 || wr_data_ff_o[15:8] == dest_data_reg_i[15:8])) else $error("upper bits disturbed");
   sign_ext_a: assert property (wr_en_o && nr && ext_word_i[11] && sz != 2'h2 |-> (sz == 2'h0 ?
      wr_data_ff_o[31:16] == {16{wr_data_ff_o[15]}} : wr_data_ff_o[31:24] == {8{wr_data_ff_o[23]}}))
      else $error("unrounded result not sign extended");
   v_clear_a: assert property (wr_en_o && (!nr || sz != 2'h2) |-> !ccr_ff_o[1]) else $error("overflow set wrongly");
   dest_sel_a: assert property (wr_en_o |-> wr_sel_ff_o == ext_word_i[14:12]) else $error("wrong destination");
endmodule // stiu_unit_chk
bind stiu_unit stiu_unit_chk u_chk (.clk_i, .reset_i, .start_i, .busy_o, .op_word_i, .ext_word_i, .dest_data_reg_i,
   .ccr_i, .mem_req_o, .wr_en_o, .illegal_o, .wr_sel_ff_o, .wr_data_ff_o, .ccr_ff_o);

// [verification/signed_table_interpolate_unit_tb.sv]
// Purpose: self-checking bench for stiu_unit
// Assumes: one instruction at a time, inputs held until result
// Notes: expected values from a reference model of the arithmetic
`timescale 1ns/1ps
// =====================================================
// testbench
module signed_table_interpolate_unit_tb;
   reg clk_i = 1'b0;
   reg reset_i = 1'b1;
   reg start_i;
   reg [15:0] op_word_i, ext_word_i;
   reg [31:0] table_base_operand_i, rd_a_data_i, rd_b_data_i, dest_data_reg_i;
   reg [4:0] ccr_i;
   reg [1:0] lat_i;
   wire [2:0] rd_a_sel_o, rd_b_sel_o, rd_d_sel_o, wr_sel_ff_o;
   wire mem_req_o, mem_ack_i, wr_en_o, busy_o, illegal_o;
   wire [31:0] mem_addr_ff_o, mem_rdata_i, wr_data_ff_o;
   wire [1:0] mem_size_ff_o;
   wire [4:0] ccr_ff_o;
   integer err_total = 0, n_tests = 0, v, r, m;
   reg [1:0] sz;
   reg [31:0] va [0:3] = '{32'hffffff05, 32'h7fffffff, 32'h0, 32'h1};
   reg [31:0] vb [0:3] = '{32'h123400fd, 32'h80000000, 32'h1, 32'h0};
   reg [31:0] vd [0:3] = '{32'hab775580, 32'h000000ff, 32'h00000080, 32'hffffff80};
   reg [5:0] tm [0:6] = '{6'h10, 6'h28, 6'h30, 6'h38, 6'h39, 6'h3a, 6'h3b};
   reg [31:0] bv [0:7] = '{32'hf7c15802, 32'hf80158c2, 32'hf8005900, 32'hf8085900,
      32'hf8185900, 32'hf8205900, 32'hf83c5900, 32'hf8105802};
   always #5 clk_i = ~clk_i;
   stiu_unit DUT (.*);
   stiu_mem_model u_mem (.clk_i(clk_i), .reset_i(reset_i), .req_i(mem_req_o), .addr_i(mem_addr_ff_o),
      .lat_i(lat_i), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   // sign extension of an entry of the given size
   function longint sx(input [31:0] x, input [1:0] s);
      sx = s == 2'h0 ? longint'($signed(x[7:0])) : s == 2'h1 ? longint'($signed(x[15:0])) : longint'($signed(x));
   endfunction
   // reference result: {ccr, written value}
   function [36:0] ref_f(input [1:0] s, input nr, input [31:0] a, input [31:0] b, input [31:0] d, input x);
      longint e0, p, q;
      reg [31:0] w, k;
      reg n, z, o;
      begin
         e0 = sx(a, s);
         p = (sx(b, s) - e0) * longint'(d[7:0]);
         k = s == 2'h0 ? 32'hff : s == 2'h1 ? 32'hffff : 32'hffffffff;
         if (nr) begin
            q = e0 * 256 + p;
            w = s == 2'h0 ? {{16{q[15]}}, q[15:0]} : s == 2'h1 ? {{8{q[23]}}, q[23:0]} : q[31:0];
            o = s == 2'h2 && ((q >>> 8) > 8388607 || (q >>> 8) < -8388608);
            n = w[31];
            z = w == 32'h0;
         end else begin
            q = e0 + (p >= 0 ? (p + 128) >>> 8 : -((128 - p) >>> 8));
            w = (d & ~k) | (q[31:0] & k);
            o = 1'b0;
            n = |(q[31:0] & k & ~(k >> 1));
            z = (q[31:0] & k) == 32'h0;
         end
         ref_f = {x, n, z, o, 1'b0, w};
      end
   endfunction
   task check(input [36:0] seen, input [36:0] exp);
      begin
         n_tests = n_tests + 1;
         if (seen !== exp) begin
            err_total = err_total + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one instruction: drive, hold until answer, compare
   task run(input [15:0] op, input [15:0] ext, input [31:0] base, input [31:0] a, input [31:0] b, input [31:0] d,
      input bad);
      integer i, k;
      reg [31:0] ad, nb;
      begin
         nb = 32'h1 << ext[7:6];
         ad = base + {24'h0, d[15:8]} * nb;
         if (ext[8]) begin
            a = ad * 32'h9e3779b1;
            b = (ad + nb) * 32'h9e3779b1;
         end
         @(posedge clk_i);
         {start_i, op_word_i, ext_word_i, table_base_operand_i, rd_a_data_i, rd_b_data_i, dest_data_reg_i, ccr_i} <=
            {1'b1, op, ext, base, ext[8] ? ~a : a, ext[8] ? ~b : b, d, ~ccr_i};
         #1;
         if (!ext[8]) check({rd_a_sel_o, rd_b_sel_o, rd_d_sel_o}, {op[2:0], ext[2:0], ext[14:12]});
         k = 0;
         for (i = 0; i < 30 && wr_en_o !== 1'b1 && illegal_o !== 1'b1; i = i + 1) begin
            @(posedge clk_i);
            start_i <= 1'b0;
            #1;
            if (mem_ack_i === 1'b1) begin
               check({mem_size_ff_o, mem_addr_ff_o}, {ext[7:6], ad + k * nb});
               k = k + 1;
            end
         end
         check({wr_en_o | illegal_o, illegal_o}, {1'b1, bad});
         if (!bad) check({ccr_ff_o, wr_data_ff_o}, ref_f(ext[7:6], ext[10], a, b, d, ccr_i[4]));
         if (!bad && ext[8]) check(k, 2);
         $display("test done op %h ext %h", op, ext);
      end
   endtask
   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_total);
         if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // main sequence: register mode, table mode, refused encodings
   initial begin
      {start_i, op_word_i, ext_word_i, table_base_operand_i, rd_a_data_i, rd_b_data_i, dest_data_reg_i} = '0;
      ccr_i = 5'h0a;
      lat_i = 2'h0;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      for (v = 0; v < 12; v = v + 1)
         for (r = 0; r < 2; r = r + 1) begin
            sz = v % 3;
            run(16'hf801, {4'h5, 1'b1, r[0], 2'h0, sz, 6'h2}, 32'h0, va[v/3], vb[v/3], vd[v/3], 1'b0);
         end
      // index up to ff needs the following entry, so tables reach 257 entries
      for (m = 0; m < 7; m = m + 1) begin
         @(posedge clk_i) lat_i <= m % 4;
         sz = m % 3;
         run({10'h3e0, tm[m]}, {4'h3, 1'b1, m[0], 2'h1, sz, 6'h0}, 32'h1000 + m * 256, 32'h0, 32'h0,
            {16'hc3c3, 8'hf9 + m[7:0], m[3:0], 4'h8}, 1'b0);
      end
      for (m = 0; m < 8; m = m + 1)
         run(bv[m][31:16], bv[m][15:0], 32'h0, 32'h0, 32'h0, 32'h0, 1'b1);
      final_report;
   end
   // watchdog well beyond the roughly 170 cycles the tests need
   initial begin
      #20000;
      err_total = err_total + 1;
      final_report;
   end
endmodule // signed_table_interpolate_unit_tb
